// file: hdl/master_i2c_control_status.sv
// Notes on behaviour
// - Enable bit 7 switches controller on/off
// - Bit 6 drives receive ack slot
// - Flag set when each byte completes
// - Writing zero to flag clears it
// - Read-only bit 4 holds slave's ack
`timescale 1ns/10ps
`default_nettype none

module master_i2c_control_status
   import i2c_ctl_pkg::*;
#(
   parameter int DIVIDE = QUARTER_CYCLES
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire reg_req_s bus_req,
   output logic [7:0] rdata,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////
   // Control and status state
   logic controller_enable;
   logic receive_ack_out;
   logic byte_flag;
   logic ack_in;
   logic start_req;
   logic stop_req;
   logic receive_dir;
   logic [IRQ_WIDTH-1:0] irq_status;
   logic [IRQ_WIDTH-1:0] irq_mask;
   logic [7:0] shifter;
   xfer_state_e state;
   logic [1:0] phase;
   logic [3:0] bit_cnt;
   logic byte_done;
   logic nack_seen;
   logic tick;
   logic busy;
   wire_pair_s raw_lines;
   wire_pair_s lines;

   function automatic logic hit(input reg_req_s req, input logic [7:0] a);
      hit = req.addr == a;
   endfunction

   wire logic wr_ctrl = bus_req.wr && hit(bus_req, ADDR_CONTROL);
   wire logic wr_data = bus_req.wr && hit(bus_req, ADDR_DATA);
   wire logic wr_status = bus_req.wr && hit(bus_req, ADDR_IRQ_STATUS);
   wire logic wr_mask = bus_req.wr && hit(bus_req, ADDR_IRQ_MASK);
   wire logic go = wr_ctrl && bus_req.wdata[BIT_GO] && controller_enable
      && bus_req.wdata[BIT_ENABLE] && (state == ST_IDLE);

   assign busy = state != ST_IDLE;
   assign raw_lines.scl = scl_in;
   assign raw_lines.sda = sda_in;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and bit timing
   line_sync #(
      .IDLE_LEVEL(2'b11)
   ) u_sync (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .raw(raw_lines),
      .synced(lines)
   );

   quarter_tick #(
      .DIVIDE(DIVIDE)
   ) u_tick (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .run(busy),
      .tick(tick)
   );

   ////////////////////////////////////////////////////////////////////////
   // Software-owned control bits
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         controller_enable <= RESET_ENABLE;
         receive_ack_out <= RESET_ACK_OUT;
         start_req <= RESET_START;
         stop_req <= RESET_STOP;
         receive_dir <= 1'b0;
      end else if (wr_ctrl) begin
         controller_enable <= bus_req.wdata[BIT_ENABLE];
         receive_ack_out <= bus_req.wdata[BIT_ACK_OUT];
         start_req <= bus_req.wdata[BIT_START];
         stop_req <= bus_req.wdata[BIT_STOP];
         receive_dir <= bus_req.wdata[BIT_RECEIVE];
      end
   end

   // Byte flag: a completing byte beats a clearing write in the same cycle
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         byte_flag <= 1'b0;
      end else if (byte_done) begin
         byte_flag <= 1'b1;
      end else if (wr_ctrl && !bus_req.wdata[BIT_FLAG]) begin
         byte_flag <= 1'b0;
      end
   end

   // Acknowledge seen from the slave while we transmit
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ack_in <= RESET_ACK_IN;
      end else if (tick && state == ST_BITS && phase == 2'd3
            && bit_cnt == ACK_SLOT && !receive_dir) begin
         ack_in <= lines.sda;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt status, mask and request line
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         irq_status <= '0;
      end else begin
         for (int i = 0; i < IRQ_WIDTH; i++) begin
            if ((i == IRQ_BYTE_DONE && byte_done)
                  || (i == IRQ_NACK && nack_seen)) begin
               irq_status[i] <= 1'b1;
            end else if (wr_status && bus_req.wdata[i]) begin
               irq_status[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         irq_mask <= '0;
      end else if (wr_mask) begin
         irq_mask <= bus_req.wdata[IRQ_WIDTH-1:0];
      end
   end

   // Both the control flag and the status register reach the line
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status & irq_mask)
            || (byte_flag && irq_mask[IRQ_BYTE_DONE]);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register reads, answered one cycle after the strobe
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rdata <= 8'h00;
      end else if (bus_req.rd) begin
         if (hit(bus_req, ADDR_CONTROL)) begin
            rdata <= {controller_enable, receive_ack_out, byte_flag,
               ack_in, start_req, stop_req, receive_dir, busy};
         end else if (hit(bus_req, ADDR_DATA)) begin
            rdata <= shifter;
         end else if (hit(bus_req, ADDR_IRQ_STATUS)) begin
            rdata <= {{(8-IRQ_WIDTH){1'b0}}, irq_status};
         end else if (hit(bus_req, ADDR_IRQ_MASK)) begin
            rdata <= {{(8-IRQ_WIDTH){1'b0}}, irq_mask};
         end else begin
            rdata <= 8'h00;
         end
      end else begin
         rdata <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Byte engine: four quarter steps per bit, SCL high in steps 2 and 3
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state <= ST_IDLE;
         phase <= 2'd0;
         bit_cnt <= 4'h0;
         shifter <= RESET_BYTE;
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
         byte_done <= 1'b0;
         nack_seen <= 1'b0;
      end else if (!controller_enable) begin
         // Disabled: drop any transfer and let go of both lines
         state <= ST_IDLE;
         phase <= 2'd0;
         bit_cnt <= 4'h0;
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
         byte_done <= 1'b0;
         nack_seen <= 1'b0;
         if (wr_data) begin
            shifter <= bus_req.wdata;
         end
      end else begin
         byte_done <= 1'b0;
         nack_seen <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (wr_data) begin
                  shifter <= bus_req.wdata;
               end
               if (go) begin
                  phase <= 2'd0;
                  bit_cnt <= 4'h0;
                  state <= bus_req.wdata[BIT_START] ? ST_START : ST_BITS;
               end
            end
            ST_START: begin
               if (tick) begin
                  case (phase)
                     2'd0: begin
                        sda_oe <= 1'b0;
                        phase <= 2'd1;
                     end
                     2'd1: begin
                        scl_oe <= 1'b0;
                        phase <= 2'd2;
                     end
                     2'd2: begin
                        // Wait out a slave that stretches the clock
                        if (lines.scl) begin
                           sda_oe <= 1'b1;
                           phase <= 2'd3;
                        end
                     end
                     default: begin
                        scl_oe <= 1'b1;
                        phase <= 2'd0;
                        state <= ST_BITS;
                     end
                  endcase
               end
            end
            ST_BITS: begin
               if (tick) begin
                  case (phase)
                     2'd0: begin
                        scl_oe <= 1'b1;
                        if (bit_cnt == ACK_SLOT) begin
                           sda_oe <= receive_dir
                              ? !receive_ack_out : 1'b0;
                        end else begin
                           sda_oe <= receive_dir ? 1'b0 : !shifter[7];
                        end
                        phase <= 2'd1;
                     end
                     2'd1: begin
                        scl_oe <= 1'b0;
                        phase <= 2'd2;
                     end
                     2'd2: begin
                        if (lines.scl) begin
                           phase <= 2'd3;
                        end
                     end
                     default: begin
                        scl_oe <= 1'b1;
                        phase <= 2'd0;
                        if (bit_cnt == ACK_SLOT) begin
                           byte_done <= 1'b1;
                           nack_seen <= !receive_dir && lines.sda;
                           bit_cnt <= 4'h0;
                           state <= stop_req ? ST_STOP : ST_IDLE;
                        end else begin
                           shifter <= {shifter[6:0], lines.sda};
                           bit_cnt <= bit_cnt + 4'h1;
                        end
                     end
                  endcase
               end
            end
            ST_STOP: begin
               if (tick) begin
                  case (phase)
                     2'd0: begin
                        sda_oe <= 1'b1;
                        phase <= 2'd1;
                     end
                     2'd1: begin
                        scl_oe <= 1'b0;
                        phase <= 2'd2;
                     end
                     2'd2: begin
                        if (lines.scl) begin
                           phase <= 2'd3;
                        end
                     end
                     default: begin
                        sda_oe <= 1'b0;
                        phase <= 2'd0;
                        state <= ST_IDLE;
                     end
                  endcase
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Open-drain pins only ever pull low
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         scl_out <= 1'b0;
         sda_out <= 1'b0;
      end else begin
         scl_out <= 1'b0;
         sda_out <= 1'b0;
      end
   end

endmodule // master_i2c_control_status

`default_nettype wire

// file: common/i2c_ctl_pkg.sv
package i2c_ctl_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register map
   localparam logic [7:0] ADDR_CONTROL = 8'hE1;
   localparam logic [7:0] ADDR_DATA = 8'hE2;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'hE3;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'hE4;

   // Control register fields
   localparam int BIT_ENABLE = 7;
   localparam int BIT_ACK_OUT = 6;
   localparam int BIT_FLAG = 5;
   localparam int BIT_ACK_IN = 4;
   localparam int BIT_START = 3;
   localparam int BIT_STOP = 2;
   localparam int BIT_RECEIVE = 1;
   localparam int BIT_GO = 0;

   // Interrupt status and mask fields
   localparam int IRQ_BYTE_DONE = 0;
   localparam int IRQ_NACK = 1;
   localparam int IRQ_WIDTH = 2;

   // Values after reset
   localparam logic RESET_ENABLE = 1'b0;
   localparam logic RESET_ACK_OUT = 1'b0;
   localparam logic RESET_ACK_IN = 1'b0;
   localparam logic RESET_START = 1'b0;
   localparam logic RESET_STOP = 1'b1;
   localparam logic [7:0] RESET_BYTE = 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // Timing: one bit on the wire is split into four quarter steps
   localparam int CLK_PERIOD_NS = 50;
   localparam int BIT_PERIOD_NS = 400;
   localparam int QUARTER_CYCLES_RAW = BIT_PERIOD_NS / (4 * CLK_PERIOD_NS);
   localparam int QUARTER_CYCLES =
      (QUARTER_CYCLES_RAW < 1) ? 1 : QUARTER_CYCLES_RAW;
   localparam logic [3:0] LAST_DATA_BIT = 4'h7;
   localparam logic [3:0] ACK_SLOT = 4'h8;

   ////////////////////////////////////////////////////////////////////////
   // Carriers
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;

   typedef struct packed {
      logic scl;
      logic sda;
   } wire_pair_s;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_START,
      ST_BITS,
      ST_STOP
   } xfer_state_e;

endpackage

// file: hdl/line_sync.sv
`timescale 1ns/10ps
`default_nettype none

module line_sync
   import i2c_ctl_pkg::*;
#(
   parameter logic [1:0] IDLE_LEVEL = 2'b11
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire wire_pair_s raw,
   output wire_pair_s synced
);

   wire_pair_s stage1;

   // Only the second stage is read outside this module
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         stage1 <= IDLE_LEVEL;
         synced <= IDLE_LEVEL;
      end else begin
         stage1 <= raw;
         synced <= stage1;
      end
   end

endmodule // line_sync

`default_nettype wire

// file: hdl/quarter_tick.sv
`timescale 1ns/10ps
`default_nettype none

module quarter_tick
   import i2c_ctl_pkg::*;
#(
   parameter int DIVIDE = QUARTER_CYCLES
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic run,
   output logic tick
);

   localparam int CW = (DIVIDE < 2) ? 1 : $clog2(DIVIDE);
   localparam logic [CW-1:0] LAST = CW'(DIVIDE - 1);

   logic [CW-1:0] count;

   // Restarts when idle so the first step of a transfer is full length
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         count <= '0;
         tick <= 1'b0;
      end else if (!run) begin
         count <= '0;
         tick <= 1'b0;
      end else if (count == LAST) begin
         count <= '0;
         tick <= 1'b1;
      end else begin
         count <= count + 1'b1;
         tick <= 1'b0;
      end
   end

endmodule // quarter_tick

`default_nettype wire

// file: verif/i2c_ctl_assertions.sv
`timescale 1ns/10ps
`default_nettype none

module i2c_ctl_checker
   import i2c_ctl_pkg::*;
#(
   parameter int DIVIDE = QUARTER_CYCLES
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire reg_req_s bus_req,
   input wire logic [7:0] rdata,
   input wire logic scl_in,
   input wire logic scl_out,
   input wire logic scl_oe,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic irq
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   logic en_q, rcv_q, ack_q, scl_q;
   logic [1:0] mask_q;
   logic [3:0] rises;
   wire logic wr_ctl = bus_req.wr && bus_req.addr == ADDR_CONTROL;
   wire logic rd_ctl = bus_req.rd && bus_req.addr == ADDR_CONTROL;
   // Raw wire edge; the design sees it two flops later
   wire logic ninth = rises == 4'h8 && scl_in && !scl_q;

   ////////////////////////////////////////
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         {en_q, rcv_q, ack_q} <= 3'h0;
      end else if (wr_ctl) begin
         en_q <= bus_req.wdata[BIT_ENABLE];
         rcv_q <= bus_req.wdata[BIT_RECEIVE];
         ack_q <= bus_req.wdata[BIT_ACK_OUT];
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         mask_q <= 2'h0;
      end else if (bus_req.wr && bus_req.addr == ADDR_IRQ_MASK) begin
         mask_q <= bus_req.wdata[1:0];
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rises <= 4'h0;
         scl_q <= 1'b1;
      end else begin
         scl_q <= scl_in;
         if (wr_ctl && bus_req.wdata[BIT_GO]) begin
            rises <= 4'h0;
         end else if (scl_in && !scl_q && rises != 4'hf) begin
            rises <= rises + 4'h1;
         end
      end
   end

   ////////////////////////////////////////
   a_unmapped_read:
      assert property (bus_req.rd && (bus_req.addr < ADDR_CONTROL ||
         bus_req.addr > ADDR_IRQ_MASK) |=> rdata == 8'h00)
      else $error("unmapped read returned data");
   a_off_idle:
      assert property (!en_q && !$past(en_q) |-> !scl_oe && !sda_oe)
      else $error("bus driven while disabled");
   a_ack_drive:
      assert property (rcv_q && ninth |-> sda_oe == !ack_q)
      else $error("ack slot level differs from ack bit");
   a_done_flag:
      assert property (ninth && mask_q[0] |-> ##[1:40] irq)
      else $error("no byte done after ack slot");
   a_flag_clear:
      assert property (wr_ctl && !bus_req.wdata[BIT_FLAG] ##1 rd_ctl
         |=> !rdata[BIT_FLAG])
      else $error("flag not cleared by zero write");
   a_ack_ro:
      assert property ($past(rd_ctl, 3) && $past(wr_ctl, 2) &&
         $past(rd_ctl) && !$past(rdata[BIT_GO], 2)
         |-> rdata[BIT_ACK_IN] == $past(rdata[BIT_ACK_IN], 2))
      else $error("ack in bit changed by write");
   a_flag_irq:
      assert property ($past(rd_ctl) && rdata[BIT_FLAG] && $past(mask_q[0])
         |-> irq)
      else $error("flag set but no irq");
   a_irq_masked:
      assert property (mask_q == 2'h0 && $past(mask_q) == 2'h0 |-> !irq)
      else $error("irq while fully masked");

   c_rx_ack: cover property (ninth && rcv_q);
   c_abort: cover property (wr_ctl && !bus_req.wdata[BIT_ENABLE] && scl_oe);
   c_irq: cover property (irq);
endmodule // i2c_ctl_checker

bind master_i2c_control_status i2c_ctl_checker #(.DIVIDE(DIVIDE)) chk (
   .clk_sys(clk_sys), .reset_n(reset_n), .bus_req(bus_req), .rdata(rdata),
   .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));

`default_nettype wire

// file: verif/i2c_slave_model.sv
`timescale 1ns/10ps
`default_nettype none

module i2c_slave_model (
   input wire logic scl,
   input wire logic sda,
   input wire logic send,
   input wire logic nack,
   input wire logic [7:0] tx_byte,
   output logic sda_pull,
   output logic [7:0] rx_byte,
   output logic ack_seen
);
   int cnt;

   initial begin
      cnt = 0;
      sda_pull = 1'b0;
      rx_byte = 8'h00;
      ack_seen = 1'b1;
   end

   // Start condition restarts the slot count
   always @(negedge sda) begin
      if (scl) begin
         cnt = 0;
      end
   end

   always @(posedge scl) begin
      if (cnt < 8) begin
         rx_byte = {rx_byte[6:0], sda};
      end
      if (cnt == 8) begin
         ack_seen = sda;
      end
      cnt = cnt + 1;
   end

   // Only moves data while the clock is low, so no false start or stop
   always @(negedge scl) begin
      if (send && cnt < 8) begin
         sda_pull = !tx_byte[7 - cnt];
      end else begin
         sda_pull = !send && !nack && cnt == 8;
      end
   end
endmodule // i2c_slave_model

`default_nettype wire

// file: verif/master_i2c_control_status_tb.sv
`timescale 1ns/10ps
`default_nettype none

module master_i2c_control_status_tb
   import i2c_ctl_pkg::*;
;
   logic clk_sys, reset_n, scl_out, scl_oe, sda_out, sda_oe, irq;
   logic sda_pull, ack_seen, send, nack, rcv, ackbit, lastack, msk;
   logic [7:0] rdata, rx_byte, tx_byte, r, c;
   logic [31:0] seed;
   reg_req_s bus_req;
   int bad_count, n_checks, k, i;
   // Open-drain wires with pull-ups
   wire logic scl_w = scl_oe ? scl_out : 1'b1;
   wire logic sda_w = (sda_oe ? sda_out : 1'b1) && !sda_pull;

   master_i2c_control_status #(.DIVIDE(QUARTER_CYCLES)) uut (
      .clk_sys(clk_sys), .reset_n(reset_n), .bus_req(bus_req),
      .rdata(rdata), .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe),
      .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
   i2c_slave_model slave (.scl(scl_w), .sda(sda_w), .send(send),
      .nack(nack), .tx_byte(tx_byte), .sda_pull(sda_pull),
      .rx_byte(rx_byte), .ack_seen(ack_seen));

   ////////////////////////////////////////
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic check(input string what, input logic [7:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic bus(input logic w, rd, input logic [7:0] a, d);
      @(posedge clk_sys);
      bus_req <= '{addr: a, wdata: d, wr: w, rd: rd};
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
      bus(1'b0, 1'b1, a, 8'h00);
      bus(1'b0, 1'b0, 8'h00, 8'h00);
      #1 v = rdata;
   endtask

   task automatic wr_reg(input logic [7:0] a, d);
      bus(1'b1, 1'b0, a, d);
      bus(1'b0, 1'b0, 8'h00, 8'h00);
   endtask

   task automatic end_of_test();
      if (bad_count == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   ////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   initial begin
      #2_000_000;
      bad_count++;
      end_of_test();
   end

   initial begin
      reset_n = 1'b0;
      bus_req = '0;
      {send, nack, lastack} = 3'h0;
      tx_byte = 8'h00;
      seed = 32'h1250_91f2;
      repeat (16) @(posedge clk_sys);
      reset_n <= 1'b1;
      rd_reg(ADDR_CONTROL, r);
      check("control reset", r, 8'h04);
      rd_reg(8'h10, r);
      check("unmapped read", r, 8'h00);
      wr_reg(ADDR_CONTROL, 8'h0d);
      rd_reg(ADDR_CONTROL, r);
      check("go while off", {6'h00, scl_oe, r[BIT_GO]}, 8'h00);
      // Go is only taken once the enable bit is already stored
      wr_reg(ADDR_CONTROL, 8'h84);
      for (k = 0; k < 12; k++) begin
         seed = xorshift(seed);
         {rcv, ackbit, nack, msk} = seed[11:8];
         if (k == 0) {rcv, nack} = 2'h1;
         if (k == 1) {rcv, ackbit} = 2'h3;
         send = rcv;
         tx_byte = seed[7:0];
         wr_reg(ADDR_IRQ_MASK, {7'h00, msk});
         wr_reg(ADDR_DATA, seed[23:16]);
         wr_reg(ADDR_CONTROL, {1'b1, ackbit, 4'hb, rcv, 1'b1});
         r = 8'h01;
         for (i = 0; i < 200 && r[BIT_GO] !== 1'b0; i++)
            rd_reg(ADDR_CONTROL, r);
         if (!rcv) lastack = nack;
         check("busy", {7'h00, r[BIT_GO]}, 8'h00);
         check("flag", {7'h00, r[BIT_FLAG]}, 8'h01);
         check("ack in", {7'h00, r[BIT_ACK_IN]}, {7'h00, lastack});
         check("irq", {7'h00, irq}, {7'h00, msk});
         rd_reg(ADDR_IRQ_STATUS, c);
         check("irq status", c, {6'h00, !rcv && nack, 1'b1});
         if (rcv) begin
            rd_reg(ADDR_DATA, c);
            check("rx byte", c, seed[7:0]);
            check("ack sent", {7'h00, ack_seen}, {7'h00, ackbit});
         end else begin
            check("tx byte", rx_byte, seed[23:16]);
         end
         // Read, write, read back to back
         bus(1'b0, 1'b1, ADDR_CONTROL, 8'h00);
         bus(1'b1, 1'b0, ADDR_CONTROL, {1'b1, ackbit, 1'b0, ~lastack, 4'h4});
         bus(1'b0, 1'b1, ADDR_CONTROL, 8'h00);
         bus(1'b0, 1'b0, 8'h00, 8'h00);
         #1 r = rdata;
         check("flag cleared", {7'h00, r[BIT_FLAG]}, 8'h00);
         check("ack kept", {7'h00, r[BIT_ACK_IN]}, {7'h00, lastack});
         check("en ack", r & 8'hc0, {1'b1, ackbit, 6'h00});
         wr_reg(ADDR_IRQ_STATUS, 8'h03);
         // The line is registered, so it drops one edge after the clear
         @(posedge clk_sys);
         #1 check("irq cleared", {7'h00, irq}, 8'h00);
      end
      // Abort in mid-byte
      send = 1'b0;
      wr_reg(ADDR_DATA, 8'ha5);
      wr_reg(ADDR_CONTROL, 8'h8d);
      repeat (20) @(posedge clk_sys);
      wr_reg(ADDR_CONTROL, 8'h04);
      @(posedge clk_sys);
      #1 check("released", {4'h0, scl_out, sda_out, scl_oe, sda_oe},
         8'h00);
      rd_reg(ADDR_CONTROL, r);
      check("abort", r & 8'h21, 8'h00);
      end_of_test();
   end
endmodule // master_i2c_control_status_tb

`default_nettype wire
